/* File: rcw_pkg.sv */
// Shared constants for the rotational coordinate ring block
package rcw_pkg;
	// Register byte offsets on the APB bus
	localparam logic [7:0] OFF_FIRST = 8'h00;
	localparam logic [7:0] OFF_LAST = 8'h04;
	localparam logic [7:0] OFF_TURN = 8'h08;
	localparam logic [7:0] OFF_TURN_ALIAS = 8'h0c;
	localparam logic [7:0] OFF_ORIGIN = 8'h10;
	localparam logic [7:0] OFF_CTRL = 8'h14;
	localparam logic [7:0] OFF_CMD = 8'h18;
	localparam logic [7:0] OFF_POS_DATA = 8'h1c;
	localparam logic [7:0] OFF_STATUS = 8'h20;
	localparam logic [7:0] OFF_IRQ_STAT = 8'h24;
	localparam logic [7:0] OFF_IRQ_MASK = 8'h28;
	localparam logic [7:0] OFF_CMD_POS = 8'h2c;
	localparam logic [7:0] OFF_FB_POS = 8'h30;
	localparam logic [7:0] OFF_ENC_POS = 8'h34;
	// Host command codes
	localparam logic [7:0] CODE_SETUP = 8'h04;
	localparam logic [7:0] CODE_POS_SET = 8'h20;
	localparam logic [7:0] CODE_SENSOR_ON = 8'h23;
	localparam logic [7:0] CODE_HOME = 8'h3a;
	// Accepted ranges of the bound and offset settings
	localparam logic signed [31:0] FIRST_MIN = -32'sd536870912;
	localparam logic signed [31:0] LAST_MAX = 32'sd536870911;
	localparam logic signed [31:0] ORIGIN_MIN = -32'sd1073741823;
	localparam logic signed [31:0] ORIGIN_MAX = 32'sd1073741823;
	// Reset values
	localparam logic [31:0] RST_BOUND = 32'h0000_0000;
	localparam logic [15:0] RST_TURN = 16'hffff;
	localparam logic [31:0] RST_ORIGIN = 32'h0000_0000;
	// Control register fields
	localparam int CTRL_REVERSE = 0;
	localparam int CTRL_ABS_ENC = 1;
	// Status register fields
	localparam int ST_ACTIVE = 0;
	localparam int ST_CONFIGURED = 1;
	localparam int ST_SOFT_LIMIT = 2;
	localparam int ST_ALARM = 3;
	// Interrupt status fields
	localparam int IRQ_ALARM = 0;
	localparam int IRQ_ACTIVATED = 1;
	localparam int IRQ_WRAP = 2;
	localparam int IRQ_W = 3;
endpackage

/* File: ring_range.sv */
// Inclusive range check of a value against the ring bounds
`timescale 1ns/1ps
module ring_range (
	input wire logic signed [31:0] first,
	input wire logic signed [31:0] last,
	input wire logic signed [31:0] value,
	output logic in_ring
);
	// Pure comparison, no state; the port avoids the language's own set operator name
	assign in_ring = (value >= first) && (value <= last);
endmodule // ring_range

/* File: ring_wrap.sv */
// Folds a sum back into the ring by one span, or truncates it linearly
`timescale 1ns/1ps
module ring_wrap (
	input wire logic active,
	input wire logic signed [31:0] first,
	input wire logic signed [31:0] last,
	input wire logic signed [32:0] sum,
	output logic [31:0] value,
	output logic wrapped
);
	logic signed [32:0] span; // Ring width, last minus first plus one
	logic signed [32:0] fold; // Sum after one correction
	assign span = 33'(last) - 33'(first) + 33'sd1;
	// One correction only: inputs must stay within one span of the ring
	always_comb begin
		fold = sum;
		wrapped = 1'b0;
		if (active && (sum > 33'(last))) begin
			fold = sum - span;
			wrapped = 1'b1;
		end else if (active && (sum < 33'(first))) begin
			fold = sum + span;
			wrapped = 1'b1;
		end
	end
	// Linear mode drops the carry, giving plain 32-bit two's complement
	assign value = fold[31:0];
endmodule // ring_wrap

/* File: rotational_coordinate_wrap.sv */
// Rotational coordinate ring for one servo axis with APB registers
//
// Decided for this implementation: the address map and register access over APB.
`timescale 1ns/1ps
module rotational_coordinate_wrap import rcw_pkg::*; (
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic [31:0] enc_position,
	input wire logic cmd_step_valid,
	input wire logic [31:0] cmd_step,
	output logic [31:0] commanded_position,
	output logic [31:0] feedback_position,
	output logic soft_limit_enable,
	output logic motor_reverse,
	output logic [15:0] turn_limit,
	output logic ring_active,
	output logic param_alarm,
	output logic irq
);
	// Settings written by software; bounds and turn limit are staged
	logic signed [31:0] first_stg_ff;
	logic signed [31:0] last_stg_ff;
	logic [15:0] turn_stg_ff;
	logic signed [31:0] origin_ff;
	logic [1:0] ctrl_ff;
	logic signed [31:0] pos_data_ff;
	// Applied settings, loaded at reset or on setup
	logic signed [31:0] first_ff;
	logic signed [31:0] last_ff;
	logic [15:0] turn_ff;
	// Axis state
	logic ring_active_ff;
	logic active_d_ff; // Ring enable one cycle late, for the rise event
	logic signed [31:0] offset_ff; // Encoder to machine displacement
	logic [31:0] cmd_ff;
	logic [31:0] fb_ff;
	logic sync_ff; // Copy feedback into command next cycle
	logic alarm_ff;
	logic [IRQ_W-1:0] irq_stat_ff;
	logic [IRQ_W-1:0] irq_mask_ff;
	logic [31:0] prdata_ff;
	// Combinational helpers
	logic wr_en;
	logic bad_wr;
	logic cmd_wr;
	logic setup_cmd;
	logic sens_cmd;
	logic home_cmd;
	logic pset_cmd;
	logic ring_cfg;
	logic abs_enc;
	logic [31:0] raw_dir;
	logic [31:0] fb_val;
	logic [31:0] cmd_val;
	logic cmd_wrapped;
	logic fb_wrapped; // Feedback sum needed a span correction
	logic origin_inside;
	logic pos_inside;
	logic cmd_inside;
	logic [IRQ_W-1:0] irq_set;
	logic [31:0] rd_mux;

	// Address match, used by the write decode; the read mux decodes with its own case
	function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
		return a == off;
	endfunction

	// Only known offsets answer without error
	function automatic logic mapped(input logic [7:0] a);
		return (a[1:0] == 2'b00) && (a <= OFF_ENC_POS);
	endfunction

	// Zero-wait slave: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;

	// Out-of-range setting writes are refused and flagged
	always_comb begin
		bad_wr = 1'b0;
		if (hit(paddr, OFF_FIRST)) begin
			bad_wr = ($signed(pwdata) < FIRST_MIN) || ($signed(pwdata) > 32'sd0);
		end else if (hit(paddr, OFF_LAST)) begin
			bad_wr = ($signed(pwdata) < 32'sd0) || ($signed(pwdata) > LAST_MAX);
		end else if (hit(paddr, OFF_ORIGIN)) begin
			bad_wr = ($signed(pwdata) < ORIGIN_MIN) || ($signed(pwdata) > ORIGIN_MAX);
		end
	end
	assign pslverr = psel && penable && (!mapped(paddr) || (pwrite && bad_wr));

	// Host command port decoded from writes to the command register
	assign cmd_wr = wr_en && hit(paddr, OFF_CMD);
	assign setup_cmd = cmd_wr && (pwdata[7:0] == CODE_SETUP);
	assign sens_cmd = cmd_wr && (pwdata[7:0] == CODE_SENSOR_ON);
	assign home_cmd = cmd_wr && (pwdata[7:0] == CODE_HOME);
	// Set-coordinates outside a configured ring is not executed
	assign pset_cmd = cmd_wr && (pwdata[7:0] == CODE_POS_SET) && (!ring_cfg || pos_inside);

	assign ring_cfg = (first_ff != 32'sd0) || (last_ff != 32'sd0);
	assign abs_enc = ctrl_ff[CTRL_ABS_ENC];

	// Staged settings; these do not steer the axis until setup
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_stg_ff <= RST_BOUND;
			last_stg_ff <= RST_BOUND;
			turn_stg_ff <= RST_TURN;
		end else if (wr_en && !bad_wr) begin
			if (hit(paddr, OFF_FIRST)) begin
				first_stg_ff <= pwdata;
			end
			if (hit(paddr, OFF_LAST)) begin
				last_stg_ff <= pwdata;
			end
			// Both turn limit offsets reach the same setting
			if (hit(paddr, OFF_TURN) || hit(paddr, OFF_TURN_ALIAS)) begin
				turn_stg_ff <= pwdata[15:0];
			end
		end
	end

	// Settings used right away
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			origin_ff <= RST_ORIGIN;
			ctrl_ff <= 2'h0;
			pos_data_ff <= 32'h0000_0000;
		end else if (wr_en && !bad_wr) begin
			if (hit(paddr, OFF_ORIGIN)) begin
				origin_ff <= pwdata;
			end
			if (hit(paddr, OFF_CTRL)) begin
				ctrl_ff <= pwdata[1:0];
			end
			if (hit(paddr, OFF_POS_DATA)) begin
				pos_data_ff <= pwdata;
			end
		end
	end

	// Applied bounds and turn limit: reset stands in for a power cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			first_ff <= RST_BOUND;
			last_ff <= RST_BOUND;
			turn_ff <= RST_TURN;
		end else if (setup_cmd) begin
			first_ff <= first_stg_ff;
			last_ff <= last_stg_ff;
			turn_ff <= turn_stg_ff;
		end
	end

	// Ring enable; new bounds need the enabling step again
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ring_active_ff <= 1'b0;
		end else if (setup_cmd) begin
			ring_active_ff <= 1'b0;
		end else if (ring_cfg && abs_enc && sens_cmd) begin
			ring_active_ff <= 1'b1;
		end else if (ring_cfg && !abs_enc && (home_cmd || pset_cmd)) begin
			ring_active_ff <= 1'b1;
		end
	end

	// Reverse mode flips the encoder count so bounds keep reference sense
	assign raw_dir = ctrl_ff[CTRL_REVERSE] ? (32'h0 - enc_position) : enc_position;
	assign motor_reverse = ctrl_ff[CTRL_REVERSE];

	// Displacement from encoder count to machine coordinates
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			offset_ff <= 32'sd0;
		end else if (sens_cmd && abs_enc) begin
			offset_ff <= origin_ff;
		end else if (home_cmd) begin
			offset_ff <= 32'h0 - raw_dir;
		end else if (pset_cmd) begin
			offset_ff <= pos_data_ff - raw_dir;
		end
	end

	// Feedback fold; a raw count far beyond one span is not fully folded
	ring_wrap u_fb_wrap (
		.active(ring_active_ff),
		.first(first_ff),
		.last(last_ff),
		.sum(33'($signed(raw_dir)) + 33'(offset_ff)),
		.value(fb_val),
		.wrapped(fb_wrapped)
	);

	// Command fold on each step
	ring_wrap u_cmd_wrap (
		.active(ring_active_ff),
		.first(first_ff),
		.last(last_ff),
		.sum(33'($signed(cmd_ff)) + 33'($signed(cmd_step))),
		.value(cmd_val),
		.wrapped(cmd_wrapped)
	);

	// Feedback position register
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			fb_ff <= 32'h0000_0000;
		end else begin
			fb_ff <= fb_val;
		end
	end

	// Reference events realign the command one cycle later
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			sync_ff <= 1'b0;
		end else begin
			sync_ff <= sens_cmd || home_cmd || pset_cmd;
		end
	end

	// Command position: realign wins over a step in the same cycle
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			cmd_ff <= 32'h0000_0000;
		end else if (sync_ff) begin
			cmd_ff <= fb_val;
		end else if (cmd_step_valid) begin
			cmd_ff <= cmd_val;
		end
	end

	// Origin offset check against the applied bounds
	ring_range u_origin_rng (
		.first(first_ff),
		.last(last_ff),
		.value(origin_ff),
		.in_ring(origin_inside)
	);

	// Set-coordinates target check
	ring_range u_pos_rng (
		.first(first_ff),
		.last(last_ff),
		.value(pos_data_ff),
		.in_ring(pos_inside)
	);

	// Command position check, also watched by the assertions
	ring_range u_cmd_rng (
		.first(first_ff),
		.last(last_ff),
		.value(cmd_ff),
		.in_ring(cmd_inside)
	);

	// Alarm level; it follows the settings, so fixing the offset clears it
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			alarm_ff <= 1'b0;
		end else begin
			alarm_ff <= ring_cfg && !origin_inside;
		end
	end

	// Delayed ring enable; comparing against the live flop finds the rise
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			active_d_ff <= 1'b0;
		end else begin
			active_d_ff <= ring_active_ff;
		end
	end

	// Events: alarm rise, ring activation, command wrap
	assign irq_set[IRQ_ALARM] = ring_cfg && !origin_inside && !alarm_ff;
	assign irq_set[IRQ_ACTIVATED] = ring_active_ff && !active_d_ff;
	assign irq_set[IRQ_WRAP] = cmd_step_valid && !sync_ff && cmd_wrapped;

	// Sticky status, write one to clear; a new event beats the clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_stat_ff <= '0;
		end else if (wr_en && hit(paddr, OFF_IRQ_STAT)) begin
			irq_stat_ff <= (irq_stat_ff & ~pwdata[IRQ_W-1:0]) | irq_set;
		end else begin
			irq_stat_ff <= irq_stat_ff | irq_set;
		end
	end

	// Interrupt mask, one enables the bit
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_mask_ff <= '0;
		end else if (wr_en && hit(paddr, OFF_IRQ_MASK)) begin
			irq_mask_ff <= pwdata[IRQ_W-1:0];
		end
	end

	// Read mux; write-only and unmapped offsets read zero
	always_comb begin
		rd_mux = 32'h0000_0000;
		case (paddr)
			OFF_FIRST: rd_mux = first_stg_ff;
			OFF_LAST: rd_mux = last_stg_ff;
			OFF_TURN: rd_mux = {16'h0000, turn_stg_ff};
			OFF_TURN_ALIAS: rd_mux = {16'h0000, turn_stg_ff};
			OFF_ORIGIN: rd_mux = origin_ff;
			OFF_CTRL: rd_mux = {30'h0, ctrl_ff};
			OFF_POS_DATA: rd_mux = pos_data_ff;
			OFF_STATUS: rd_mux = {28'h0, alarm_ff, soft_limit_enable, ring_cfg, ring_active_ff};
			OFF_IRQ_STAT: rd_mux = {29'h0, irq_stat_ff};
			OFF_IRQ_MASK: rd_mux = {29'h0, irq_mask_ff};
			OFF_CMD_POS: rd_mux = cmd_ff;
			OFF_FB_POS: rd_mux = fb_ff;
			OFF_ENC_POS: rd_mux = enc_position;
			default: rd_mux = 32'h0000_0000;
		endcase
	end

	// Read data is captured in the setup cycle so it comes from a flop
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= 32'h0000_0000;
		end else if (psel && !penable && !pwrite) begin
			prdata_ff <= rd_mux;
		end
	end

	// Outputs
	assign prdata = prdata_ff;
	assign commanded_position = cmd_ff;
	assign feedback_position = fb_ff;
	assign soft_limit_enable = !ring_cfg;
	assign turn_limit = turn_ff;
	assign ring_active = ring_active_ff;
	assign param_alarm = alarm_ff;
	assign irq = |(irq_stat_ff & irq_mask_ff);

	// Helper: a step no wider than one span either way
	logic step_small;
	assign step_small = ($signed(cmd_step) <= (last_ff - first_ff + 32'sd1))
		&& ($signed(cmd_step) >= (first_ff - last_ff - 32'sd1));

	// Setup command alone; the load of the applied values is checked one cycle later by a_setup_load
	sequence s_setup;
		setup_cmd;
	endsequence
	sequence s_step_in_ring;
		ring_active_ff && cmd_inside && cmd_step_valid && !sync_ff && step_small;
	endsequence

	a_soft_limit_off: assert property (@(posedge pclk) disable iff (!presetn)
		soft_limit_enable == ((first_ff == 32'sd0) && (last_ff == 32'sd0)))
		else $error("soft limit state wrong for bounds");
	a_bound_reject: assert property (@(posedge pclk) disable iff (!presetn)
		wr_en && hit(paddr, OFF_FIRST) && ($signed(pwdata) > 32'sd0)
		|=> $stable(first_stg_ff)) else $error("bad first bound stored");
	a_applied_hold: assert property (@(posedge pclk) disable iff (!presetn)
		!setup_cmd |=> $stable(first_ff) && $stable(last_ff) && $stable(turn_ff))
		else $error("applied setting moved without setup");
	a_setup_load: assert property (@(posedge pclk) disable iff (!presetn)
		s_setup |=> (first_ff == $past(first_stg_ff)) && (last_ff == $past(last_stg_ff))
		&& (turn_ff == $past(turn_stg_ff)))
		else $error("setup did not load staged values");
	a_sensor_act: assert property (@(posedge pclk) disable iff (!presetn)
		sens_cmd && abs_enc && ring_cfg && !setup_cmd |=> ring_active_ff ##1 sync_ff == 1'b0)
		else $error("sensor-on did not activate ring");
	a_home_act: assert property (@(posedge pclk) disable iff (!presetn)
		home_cmd && !abs_enc && ring_cfg |=> ring_active_ff ##1 cmd_ff == $past(fb_val))
		else $error("home did not activate ring");
	a_cmd_in_ring: assert property (@(posedge pclk) disable iff (!presetn)
		s_step_in_ring |=> cmd_inside) else $error("command left the ring");
	a_linear_step: assert property (@(posedge pclk) disable iff (!presetn)
		!ring_active_ff && cmd_step_valid && !sync_ff
		|=> cmd_ff == $past(cmd_ff) + $past(cmd_step)) else $error("linear step wrong");
	a_alarm_range: assert property (@(posedge pclk) disable iff (!presetn)
		ring_cfg && ((origin_ff < first_ff) || (origin_ff > last_ff)) |=> alarm_ff)
		else $error("origin outside ring without alarm");
	a_origin_apply: assert property (@(posedge pclk) disable iff (!presetn)
		sens_cmd && abs_enc |=> offset_ff == $past(origin_ff))
		else $error("origin offset not applied");
	a_reverse_dir: assert property (@(posedge pclk) disable iff (!presetn)
		motor_reverse && !fb_wrapped |=> fb_ff == $past(offset_ff) - $past(enc_position))
		else $error("reverse not applied");
endmodule // rotational_coordinate_wrap

/* File: host_model.sv */
// Host controller model: APB master that configures and commands the ring axis
`timescale 1ns/1ps
module host_model (
	input wire logic pclk,
	input wire logic pready,
	input wire logic pslverr,
	input wire logic [31:0] prdata,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [7:0] paddr,
	output logic [31:0] pwdata
);
	// Bus idles low from time zero so no request precedes reset release
	initial begin
		psel <= 1'b0;
		penable <= 1'b0;
		pwrite <= 1'b0;
		paddr <= 8'h00;
		pwdata <= 32'h0000_0000;
	end

	// One transfer: setup, then access held until pready seen at a rising edge
	task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
		output logic [31:0] rd, output logic err);
		@(posedge pclk);
		psel <= 1'b1;
		penable <= 1'b0;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'b1;
		// No fixed wait count is assumed; the bench timeout cuts a hang
		do @(posedge pclk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask

	// Origin offset folded into the ring by one span before it is written
	function automatic logic [31:0] norm(input int off, input int first, input int last);
		if (off < first) begin
			return off + (last - first + 1);
		end else if (off > last) begin
			return off - (last - first + 1);
		end
		return off;
	endfunction
endmodule // host_model

/* File: rotational_coordinate_wrap_tb.sv */
// Self-checking bench for the rotational coordinate ring block
`timescale 1ns/1ps
module rotational_coordinate_wrap_tb import rcw_pkg::*; ;
	logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e;
	logic [7:0] paddr;
	logic [31:0] pwdata, prdata, rdv, enc_position, cmd_step, commanded_position, feedback_position;
	logic cmd_step_valid, soft_limit_enable, motor_reverse, ring_active, param_alarm, irq;
	logic [15:0] turn_limit;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;

	rotational_coordinate_wrap u_dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.enc_position(enc_position), .cmd_step_valid(cmd_step_valid), .cmd_step(cmd_step),
		.commanded_position(commanded_position), .feedback_position(feedback_position),
		.soft_limit_enable(soft_limit_enable), .motor_reverse(motor_reverse), .turn_limit(turn_limit),
		.ring_active(ring_active), .param_alarm(param_alarm), .irq(irq));
	host_model u_host (.pclk(pclk), .pready(pready), .pslverr(pslverr), .prdata(prdata), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));

	// 250 MHz clock
	initial begin
		pclk = 1'b0;
		forever #2 pclk = ~pclk;
	end

	// Verdict and end of run, reached from the main sequence or the timeout
	task automatic end_sim();
		if (err_total == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask

	// Word comparison, four-state exact
	task automatic chk32(input string nm, input logic [31:0] x, input logic [31:0] g);
		n_tests++;
		if (g !== x) begin
			err_total++;
			$display("FAIL %s expected %h seen %h", nm, x, g);
		end
	endtask

	// Flag comparison, four-state exact
	task automatic chk1(input string nm, input logic x, input logic g);
		n_tests++;
		if (g !== x) begin
			err_total++;
			$display("FAIL %s expected %b seen %b", nm, x, g);
		end
	endtask

	// Bus wrappers; the extra 1 ns lets the access edge's updates land
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		u_host.xfer(1'b1, a, d, rdv, e);
		#1;
	endtask
	task automatic rd(input logic [7:0] a);
		u_host.xfer(1'b0, a, 32'h0, rdv, e);
		#1;
	endtask

	// One command step, then settle past its one-cycle latency
	task automatic step(input logic [31:0] s);
		@(posedge pclk);
		cmd_step_valid <= 1'b1;
		cmd_step <= s;
		@(posedge pclk);
		cmd_step_valid <= 1'b0;
		@(posedge pclk);
		#1;
	endtask

	// Wait two edges: feedback and commanded both follow a command by one cycle
	task automatic settle();
		repeat (2) @(posedge pclk);
		#1;
	endtask

	// Hang guard, well above the roughly 130 cycles the tests need
	always @(posedge pclk) begin
		cyc <= cyc + 1;
		if (cyc == 5000) begin
			err_total++;
			end_sim();
		end
	end

	// Main sequence, host setup in the documented order
	initial begin
		presetn = 1'b0;
		enc_position = 32'h0;
		cmd_step_valid = 1'b0;
		cmd_step = 32'h0;
		repeat (8) @(posedge pclk);
		presetn <= 1'b1;
		rd(OFF_FIRST); chk32("first_rst", 32'h0, rdv);
		rd(OFF_TURN); chk32("turn_rst", 32'hffff, rdv);
		rd(OFF_TURN_ALIAS); chk32("alias_rst", 32'hffff, rdv);
		rd(OFF_STATUS); chk32("status_rst", 32'h4, rdv);
		rd(8'h40); chk1("unmapped_err", 1'b1, e);
		chk32("unmapped_data", 32'h0, rdv);
		wr(OFF_FIRST, 32'h1); chk1("first_over_err", 1'b1, e);
		wr(OFF_LAST, 32'h2000_0000); chk1("last_over_err", 1'b1, e);
		wr(OFF_FIRST, FIRST_MIN); chk1("first_min_err", 1'b0, e);
		rd(OFF_FIRST); chk32("first_min", FIRST_MIN, rdv);
		// Linear mode wraps at 32 bits with no ring folding
		step(32'h7fff_ffff);
		step(32'h1); chk32("cmd_linear", 32'h8000_0000, commanded_position);
		// Bounds and turn limit staged, applied only by setup
		wr(OFF_FIRST, -32'sd100);
		wr(OFF_LAST, 32'd99);
		wr(OFF_TURN, 32'd99);
		chk32("turn_staged", 32'hffff, {16'h0, turn_limit});
		chk1("softlim_staged", 1'b1, soft_limit_enable);
		wr(OFF_CMD, CODE_SETUP);
		chk32("turn_applied", 32'h63, {16'h0, turn_limit});
		chk1("softlim_off", 1'b0, soft_limit_enable);
		rd(OFF_STATUS); chk32("status_bounds", 32'h2, rdv);
		// Origin outside the ring raises the alarm; normalised value clears it
		wr(OFF_IRQ_MASK, 32'h1);
		wr(OFF_ORIGIN, 32'd150);
		settle(); chk1("alarm_set", 1'b1, param_alarm);
		chk1("irq_alarm", 1'b1, irq);
		wr(OFF_ORIGIN, u_host.norm(150, -100, 99));
		settle(); chk1("alarm_clr", 1'b0, param_alarm);
		wr(OFF_IRQ_STAT, 32'h1); chk1("irq_cleared", 1'b0, irq);
		// Absolute encoder: sensor-on activates and applies the offset
		@(posedge pclk);
		enc_position <= 32'd30;
		wr(OFF_CTRL, 32'h2);
		wr(OFF_CMD, CODE_SENSOR_ON);
		settle(); chk1("active_abs", 1'b1, ring_active);
		chk32("fb_abs", -32'sd20, feedback_position);
		chk32("cmd_eq_fb", -32'sd20, commanded_position);
		step(32'd130); chk32("cmd_over", -32'sd90, commanded_position);
		step(-32'sd20); chk32("cmd_under", 32'd90, commanded_position);
		rd(OFF_IRQ_STAT); chk32("irq_stat", 32'h6, rdv);
		// Reverse rotation negates the encoder, bounds unchanged
		wr(OFF_CTRL, 32'h3);
		settle(); chk1("reverse", 1'b1, motor_reverse);
		chk32("fb_rev", -32'sd80, feedback_position);
		@(posedge pclk);
		enc_position <= 32'd60;
		settle(); chk32("fb_rev_fold", 32'd90, feedback_position);
		// Incremental encoder: set-coordinates, then home, each after setup
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CMD, CODE_SETUP); chk1("setup_deact", 1'b0, ring_active);
		// Set-coordinates outside the ring is not executed
		wr(OFF_POS_DATA, 32'd200);
		wr(OFF_CMD, CODE_POS_SET);
		settle(); chk1("pos_refused", 1'b0, ring_active);
		chk32("fb_pos_refused", 32'd10, feedback_position);
		wr(OFF_POS_DATA, 32'd40);
		wr(OFF_CMD, CODE_POS_SET);
		settle(); chk1("active_pos", 1'b1, ring_active);
		chk32("fb_pos", 32'd40, feedback_position);
		wr(OFF_CMD, CODE_SETUP);
		wr(OFF_CMD, CODE_HOME);
		settle(); chk1("active_home", 1'b1, ring_active);
		chk32("fb_home", 32'h0, feedback_position);
		end_sim();
	end
endmodule // rotational_coordinate_wrap_tb
